// ### sto_eval_defines.vh
/*
 constants for the fail-safe input torque-off evaluator.
 assumes a 25 MHz system clock; times given in microseconds.
*/
`ifndef STO_EVAL_DEFINES_VH
`define STO_EVAL_DEFINES_VH
`define CLK_HZ 25000000
`define TOL_TIME_US 500000
`define DEB_TIME_US 1000
`define TEST_ON_US 1000
`define TEST_OFF_US 4000
`define US_CYCLES(t) (((t) * (`CLK_HZ / 1000000)))
`define CMD_RESET_PARAMS 8'h05
`define CMD_IDLE 8'h00
`define FILT_COMMISSION 8'h5F
`define FILT_READY 8'h00
`define ENABLE_OFF 1'b0
`define ENABLE_BASIC 1'b1
`define PASSWORD_DEFAULT 32'h00000000
`define RESET_CYCLES 8'h10
`define CHANGE_WINDOW_US 100000
`define CHANGE_LIMIT 8'h10
`endif

// ### sto_eval.v
/*
 fail-safe two-channel input evaluator selecting safe torque off.
 assumes raw input pins asynchronous to clk_i; settings arrive as
 plain ports from a parameter manager on the same clock.
*/
`timescale 1ns/1ps
// Operation
// - compare both input channels continuously
// - tolerate mismatch for set tolerance time
// - any channel high-to-low selects torque off
// - persistent mismatch flags a wiring fault
// - configurable debounce filter, default one ms
// - filter: act only after stable debounce
// - too many changes per interval faults
// - torque off active flag reads one
// - enable zero inhibits, one enables basic
// - command five resets params, then zero
// - settings change only in commissioning state
// - password default zero, range one upward, twice
// - bad password keeps the old value
// - safety filter independent of standard debounce
`include "sto_eval_defines.vh"
module sto_eval #(
  parameter TOL_DEFAULT = `US_CYCLES(`TOL_TIME_US),
  parameter DEB_DEFAULT = `US_CYCLES(`DEB_TIME_US),
  parameter WIN_CYCLES = `US_CYCLES(`CHANGE_WINDOW_US),
  parameter [7:0] CHANGE_LIMIT = `CHANGE_LIMIT
) (
  input wire clk_i,
  input wire rstn_i,
  input wire [1:0] failsafe_input_pair_i,
  input wire [7:0] commissioning_filter_i,
  input wire set_wr_i,
  input wire [23:0] discrepancy_tolerance_time_i,
  input wire [23:0] input_debounce_time_i,
  input wire safety_function_enable_i,
  input wire cmd_wr_i,
  input wire [7:0] parameter_reset_command_i,
  input wire pw_wr_i,
  input wire [31:0] new_password_entry_i,
  input wire [31:0] confirm_password_entry_i,
  input wire [31:0] password_entry_i,
  input wire fault_clear_i,
  output reg safe_torque_off_o,
  output reg torque_off_active_flag_o,
  output reg wiring_fault_o,
  output reg change_fault_o,
  output reg [7:0] parameter_reset_command_o,
  output reg password_ok_o,
  output reg password_rejected_o,
  output reg [1:0] filtered_pair_o
);
  reg [1:0] s1, s2, s3;
  wire [1:0] filt;
  reg [1:0] filt_d;
  reg [23:0] tol_cnt;
  reg [23:0] tol_set;
  reg [23:0] deb_set;
  reg enable;
  reg [31:0] password;
  reg [23:0] win_cnt;
  reg [7:0] chg_cnt;
  reg [7:0] rst_cnt;
  reg resetting;
  wire commissioning = (commissioning_filter_i == `FILT_COMMISSION);
  wire [1:0] stable = ~(s2 ^ s3);
  wire mismatch = filt[0] ^ filt[1];
  wire [1:0] falls = filt_d & ~filt;
  wire [1:0] edges = filt_d ^ filt;
  wire [23:0] tol_def = TOL_DEFAULT[23:0];
  wire [23:0] deb_def = DEB_DEFAULT[23:0];
  // input synchronisers, three stages per channel
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1 <= 2'h3;
      s2 <= 2'h3;
      s3 <= 2'h3;
    end else begin
      s1 <= failsafe_input_pair_i;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // per-channel debounce, own timer separate from standard inputs
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      reg [23:0] cnt;
      reg level;
      assign filt[g] = level;
      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          cnt <= 24'h000000;
          level <= 1'b1;
        end else if (!stable[g] || s3[g] == level) begin
          cnt <= 24'h000000;
        end else if (cnt + 24'h000001 >= deb_set) begin
          level <= s3[g];
          cnt <= 24'h000000;
        end else begin
          cnt <= cnt + 24'h000001;
        end
      end
    end
  endgenerate
  // settings, parameter reset and password store
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tol_set <= 24'h000000;
      deb_set <= 24'h000000;
      enable <= `ENABLE_OFF;
      password <= `PASSWORD_DEFAULT;
      resetting <= 1'b1;
      rst_cnt <= 8'h00;
      parameter_reset_command_o <= `CMD_IDLE;
      password_ok_o <= 1'b0;
      password_rejected_o <= 1'b0;
    end else begin
      password_ok_o <= 1'b0;
      password_rejected_o <= 1'b0;
      if (resetting) begin
        tol_set <= tol_def;
        deb_set <= deb_def;
        enable <= `ENABLE_OFF;
        password <= `PASSWORD_DEFAULT;
        if (rst_cnt == `RESET_CYCLES) begin
          resetting <= 1'b0;
          rst_cnt <= 8'h00;
          parameter_reset_command_o <= `CMD_IDLE;
        end else begin
          rst_cnt <= rst_cnt + 8'h01;
        end
      end else if (commissioning) begin
        if (cmd_wr_i && parameter_reset_command_i == `CMD_RESET_PARAMS
            && password_entry_i == password) begin
          resetting <= 1'b1;
          parameter_reset_command_o <= `CMD_RESET_PARAMS;
        end else if (set_wr_i && password_entry_i == password) begin
          tol_set <= discrepancy_tolerance_time_i;
          deb_set <= input_debounce_time_i;
          enable <= safety_function_enable_i;
        end
        if (pw_wr_i) begin
          if (password_entry_i == password
              && new_password_entry_i != 32'h00000000
              && new_password_entry_i == confirm_password_entry_i) begin
            password <= new_password_entry_i;
            password_ok_o <= 1'b1;
          end else begin
            password_rejected_o <= 1'b1;
          end
        end
      end
    end
  end
  // discrepancy monitor and change counter
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      filt_d <= 2'h3;
      tol_cnt <= 24'h000000;
      win_cnt <= 24'h000000;
      chg_cnt <= 8'h00;
      wiring_fault_o <= 1'b0;
      change_fault_o <= 1'b0;
    end else begin
      filt_d <= filt;
      if (!mismatch) begin
        tol_cnt <= 24'h000000;
      end else if (tol_cnt >= tol_set) begin
        wiring_fault_o <= 1'b1;
      end else begin
        tol_cnt <= tol_cnt + 24'h000001;
      end
      if (win_cnt + 24'h000001 >= WIN_CYCLES[23:0]) begin
        win_cnt <= 24'h000000;
        chg_cnt <= 8'h00;
      end else begin
        win_cnt <= win_cnt + 24'h000001;
        if (edges != 2'h0 && chg_cnt != 8'hFF) begin
          chg_cnt <= chg_cnt + 8'h01;
        end
      end
      if (chg_cnt > CHANGE_LIMIT) begin
        change_fault_o <= 1'b1;
      end else if (fault_clear_i && !mismatch) begin
        change_fault_o <= 1'b0;
      end
      if (fault_clear_i && !mismatch && tol_cnt < tol_set) begin
        wiring_fault_o <= 1'b0;
      end
    end
  end
  // torque off selection and status
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      safe_torque_off_o <= 1'b1;
      torque_off_active_flag_o <= 1'b1;
      filtered_pair_o <= 2'h3;
    end else begin
      filtered_pair_o <= filt;
      if (enable != `ENABLE_BASIC) begin
        safe_torque_off_o <= 1'b0;
        torque_off_active_flag_o <= 1'b0;
      end else if (falls != 2'h0 || filt != 2'h3 || wiring_fault_o
                   || change_fault_o) begin
        safe_torque_off_o <= 1'b1;
        torque_off_active_flag_o <= 1'b1;
      end else begin
        safe_torque_off_o <= 1'b0;
        torque_off_active_flag_o <= 1'b0;
      end
    end
  end
endmodule

// ### sto_eval_assertions.sv
/* port assertions for sto_eval.
 bound to sto_eval; one clock domain. */
`timescale 1ns/1ps
module sto_eval_assertions (
  input wire clk_i,
  input wire rstn_i,
  input wire [7:0] commissioning_filter_i,
  input wire cmd_wr_i,
  input wire pw_wr_i,
  input wire fault_clear_i,
  input wire safe_torque_off_o,
  input wire torque_off_active_flag_o,
  input wire wiring_fault_o,
  input wire [7:0] parameter_reset_command_o,
  input wire password_ok_o,
  input wire password_rejected_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence cmd_busy;
    parameter_reset_command_o == 8'h05;
  endsequence
  flag_mirror_a: assert property (
    torque_off_active_flag_o == safe_torque_off_o) else $error("flag");
  cmd_finish_a: assert property (
    cmd_busy |-> ##[1:20] !parameter_reset_command_o) else $error("cmd");
  cmd_codes_a: assert property (
    parameter_reset_command_o == 8'h05 ||
    parameter_reset_command_o == 8'h00) else $error("code");
  cmd_locked_a: assert property (
    $rose(parameter_reset_command_o == 8'h05) |->
    $past(commissioning_filter_i) == 8'h5F && $past(cmd_wr_i))
    else $error("lock");
  pw_locked_a: assert property (
    password_ok_o |-> $past(commissioning_filter_i) == 8'h5F &&
    $past(pw_wr_i)) else $error("pwlock");
  pw_excl_a: assert property (
    !(password_ok_o && password_rejected_o)) else $error("pw");
  fault_sticky_a: assert property (
    wiring_fault_o && !fault_clear_i |=> wiring_fault_o) else $error("wf");
  fault_clear_a: assert property (
    $fell(wiring_fault_o) |-> $past(fault_clear_i)) else $error("clr");
endmodule
bind sto_eval sto_eval_assertions chk_u (.*);

// ### sto_eval_partner.sv
/* two-contact sensor model.
 driven by the bench at the falling edge. */
`timescale 1ns/1ps
module sto_eval_partner (
  input wire run_i,
  input wire broken_i,
  input wire test_i,
  output wire [1:0] pair_o
);
  // off test drops both contacts; break opens one
  assign pair_o = {run_i & ~test_i, run_i & ~broken_i & ~test_i};
endmodule

// ### failsafe_input_torque_off_eval_tb_top.sv
/* bench for sto_eval.
 assumes partner model and checker compiled alongside. */
`timescale 1ns/1ps
module failsafe_input_torque_off_eval_tb_top;
  reg clk_i = 1'h0, rstn_i = 1'h0, set_wr = 1'h0, cmd_wr = 1'h0;
  reg pw_wr = 1'h0, en = 1'h0, fclr = 1'h0, run = 1'h1, brk = 1'h0;
  reg tst = 1'h0;
  reg [7:0] filt = 8'h5F, cmd = 8'h05;
  reg [31:0] pn = 32'h0, pc = 32'h0, pe = 32'h0;
  wire [1:0] pair;
  wire stof, cf, ok, rej, wf, flag;
  wire [1:0] fp;
  wire [7:0] cmo;
  int mismatches = 0, compares = 0, i;
  always #20 clk_i = ~clk_i;
  sto_eval_partner p_u (.run_i(run), .broken_i(brk), .test_i(tst),
    .pair_o(pair));
  sto_eval #(.TOL_DEFAULT(50), .DEB_DEFAULT(5), .WIN_CYCLES(200)) dut_u (
    .clk_i, .rstn_i, .failsafe_input_pair_i(pair), .set_wr_i(set_wr),
    .commissioning_filter_i(filt), .safety_function_enable_i(en),
    .discrepancy_tolerance_time_i(24'h32), .input_debounce_time_i(24'h5),
    .cmd_wr_i(cmd_wr), .parameter_reset_command_i(cmd), .pw_wr_i(pw_wr),
    .new_password_entry_i(pn), .confirm_password_entry_i(pc),
    .password_entry_i(pe), .fault_clear_i(fclr), .safe_torque_off_o(stof),
    .torque_off_active_flag_o(flag), .wiring_fault_o(wf),
    .change_fault_o(cf), .parameter_reset_command_o(cmo),
    .password_ok_o(ok), .password_rejected_o(rej), .filtered_pair_o(fp));
  task cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic hit(ref reg s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    cyc(16);
    rstn_i = 1'h1;
    cyc(18);
    chk("stof", stof, 8'h00);
    hit(pw_wr);
    chk("rej", rej, 8'h01);
    pn = 32'h1234;
    pc = 32'h1234;
    hit(pw_wr);
    chk("ok", ok, 8'h01);
    pe = 32'h1234;
    en = 1'h1;
    hit(set_wr);
    cyc(20);
    chk("run", stof, 8'h00);
    tst = 1'h1;
    cyc(3);
    tst = 1'h0;
    cyc(12);
    chk("pulse", stof, 8'h00);
    run = 1'h0;
    cyc(6);
    chk("early", stof, 8'h00);
    for (i = 0; i < 8 && stof !== 1'h1; i++) cyc(1);
    chk("stof", stof, 8'h01);
    chk("flag", flag, 8'h01);
    chk("fp", fp, 8'h00);
    run = 1'h1;
    repeat (2) begin
      cyc(20);
      brk = 1'h1;
      cyc(30);
      brk = 1'h0;
    end
    cyc(20);
    chk("wf", wf, 8'h00);
    brk = 1'h1;
    cyc(70);
    chk("wf", wf, 8'h01);
    brk = 1'h0;
    cyc(20);
    hit(fclr);
    chk("clr", wf, 8'h00);
    // pulses long enough to pass the filter, over two full windows
    repeat (30) begin
      tst = 1'h1;
      cyc(8);
      tst = 1'h0;
      cyc(8);
    end
    chk("cf", cf, 8'h01);
    filt = 8'h00;
    hit(cmd_wr);
    chk("lock", cmo, 8'h00);
    filt = 8'h5F;
    hit(cmd_wr);
    chk("cmd", cmo, 8'h05);
    for (i = 0; i < 20 && cmo !== 8'h00; i++) cyc(1);
    chk("done", cmo, 8'h00);
    // power cycle after the parameter reset
    rstn_i = 1'h0;
    cyc(2);
    rstn_i = 1'h1;
    cyc(18);
    chk("rst_stof", stof, 8'h00);
    chk("rst_cmd", cmo, 8'h00);
    pe = 32'h0;
    pn = 32'h55;
    pc = 32'h55;
    hit(pw_wr);
    chk("def_pw", ok, 8'h01);
    end_sim;
  end
endmodule
